// *** hdl/mmp_ctrl.sv ***
// Memory-map position control registers with Avalon-MM slave and decode.
// Operation
// - The register-block position is write-once in normal and emulation modes and free in special modes.
// - The register block spans 1K or 2K bytes on any 2K boundary in the low 32K.
// - A fixed zero plus four position bits form the upper five base bits, 0x0000 to 0x7FFF.
// - EEPROM position bits 7:3 give the upper five bits of the EEPROM base.
// - The EEPROM is absent when its enable is 0 and decoded at its base when 1.
// - The EEPROM enable bit is writable at any time in every mode.
// - EEPROM position bits are free or write-once by an integration choice.
// - Writes to the EEPROM and miscellaneous registers act one cycle later.
// - Reset loads stretch 11, hide 0, and flash enable by mode.
// - Stretch, hide and flash enable are write-once outside special modes.
// - Stretch bits 3:2 set the E clocks added to external accesses.
// - Stretch codes 00 to 11 add 0 to 3 E clocks.
// - In single-chip and peripheral modes the stretch has no effect.
// - Hide blocks the low fixed flash pages but not the page window.
// - Flash enable 0 removes the flash from the map, 1 decodes it.
// - The two test registers read at any time and ignore writes.
`timescale 1ns/1ns
module mmp_ctrl
  import mmp_pkg::*;
#(
  parameter logic [3:0] P_REG_POS_RST = 4'h0,
  parameter logic [4:0] P_EE_BASE_RST = 5'h0,
  parameter logic P_EE_EN_RST = 1'b0,
  parameter logic P_FLASH_RST_EXP = 1'b0,
  parameter logic P_EE_POS_ONCE = 1'b0,
  parameter logic P_REG_2K = 1'b1,
  parameter logic [7:0] P_TEST_A_VAL = 8'h00,
  parameter logic [7:0] P_TEST_B_VAL = 8'h00
) (
  input wire logic i_core_clk, // Core clock, 50 MHz.
  input wire logic i_rst, // Synchronous reset, active high.
  input wire mmp_mode_t i_mode, // Operating mode from core logic.
  input wire logic [2:0] i_avs_address, // Word index.
  input wire logic i_avs_read, // Read request.
  input wire logic i_avs_write, // Write request.
  input wire logic [31:0] i_avs_writedata, // Write data.
  input wire logic [3:0] i_avs_byteenable, // Byte lanes.
  input wire logic [15:0] i_cpu_addr, // Core access address.
  output logic [31:0] o_avs_readdata, // Read data.
  output logic o_avs_waitrequest, // Stall, high by default.
  output mmp_map_t o_map, // Current map settings.
  output mmp_hit_t o_hit // Decode of i_cpu_addr, one cycle late.
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK = 2'b10
  } mmp_bus_st_t;

  mmp_bus_st_t st_reg;
  mmp_bus_st_t st_next;
  logic wait_reg;
  logic wait_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  mmp_map_t map_reg;
  mmp_map_t map_next;
  mmp_hit_t hit_reg;
  mmp_hit_t hit_next;
  logic [WO_N-1:0] once_reg;
  logic [WO_N-1:0] once_next;
  logic [WO_N-1:0] fld_wr;
  logic [WO_N-1:0] fld_ok;
  logic special;
  logic single;
  logic wr_fire;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic flash_rst;
  mmp_map_t omap_reg;
  mmp_map_t omap_next;

  // Peripheral counts as special for write rights; emulation as normal.
  assign special = (i_mode == MD_SPEC_SINGLE) || (i_mode == MD_SPEC_TEST)
                || (i_mode == MD_PERIPH);
  assign single = (i_mode == MD_NORM_SINGLE) || (i_mode == MD_SPEC_SINGLE)
               || (i_mode == MD_PERIPH);
  assign wr_fire = (st_reg == ST_ACK) && i_avs_write && i_avs_byteenable[0];
  assign wbyte = i_avs_writedata[7:0];

  // Bus handshake: every access is answered one cycle after it is seen.
  always_comb begin
    st_next = st_reg;
    wait_next = 1'b1;
    case (st_reg)
      ST_IDLE: begin
        if (i_avs_read || i_avs_write) begin
          st_next = ST_ACK;
          wait_next = 1'b0;
        end
      end
      ST_ACK: begin
        st_next = ST_IDLE;
      end
      default: begin
        st_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st_reg <= ST_IDLE;
      wait_reg <= 1'b1;
    end else begin
      st_reg <= st_next;
      wait_reg <= wait_next;
    end
  end

  // Read mux; test registers return fixed values, unmapped words read zero.
  always_comb begin
    rbyte = 8'h00;
    case (i_avs_address)
      IDX_REG_POS: rbyte[REG_POS_LSB+:4] = map_reg.reg_pos;
      IDX_EE_POS: begin
        rbyte[EE_POS_LSB+:5] = map_reg.ee_base;
        rbyte[EE_EN_BIT] = map_reg.ee_en;
      end
      IDX_MISC: begin
        rbyte[STR_LSB+:2] = map_reg.stretch;
        rbyte[HIDE_BIT] = map_reg.hide;
        rbyte[FLASH_BIT] = map_reg.flash_en;
      end
      IDX_TEST_A: rbyte = P_TEST_A_VAL;
      IDX_TEST_B: rbyte = P_TEST_B_VAL;
      default: rbyte = 8'h00;
    endcase
    rdata_next = rdata_reg;
    if (st_reg == ST_IDLE && i_avs_read) begin
      rdata_next = {24'h000000, rbyte};
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rdata_reg <= 32'h00000000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Which write-once field a completing write touches.
  always_comb begin
    fld_wr = '0;
    if (wr_fire) begin
      case (i_avs_address)
        IDX_REG_POS: fld_wr[WO_REG] = 1'b1;
        IDX_EE_POS: fld_wr[WO_EE] = 1'b1;
        IDX_MISC: begin
          fld_wr[WO_STR] = 1'b1;
          fld_wr[WO_HIDE] = 1'b1;
          fld_wr[WO_FLASH] = 1'b1;
        end
        default: fld_wr = '0;
      endcase
    end
  end

  // One flag per field; a spent flag blocks writes outside special modes.
  genvar g;
  generate
    for (g = 0; g < WO_N; g++) begin : g_once
      always_comb begin
        fld_ok[g] = fld_wr[g] && (special || !once_reg[g]);
        once_next[g] = once_reg[g] | fld_wr[g];
      end
    end
  endgenerate

  // Flash enable reset value depends on the mode seen during reset.
  always_comb begin
    case (i_mode)
      MD_NORM_SINGLE, MD_PERIPH: flash_rst = FLASH_RST_ON;
      MD_SPEC_TEST: flash_rst = FLASH_RST_TEST;
      MD_NORM_EXP, MD_EMUL: flash_rst = P_FLASH_RST_EXP;
      default: flash_rst = FLASH_RST_ON;
    endcase
  end

  always_comb begin
    map_next = map_reg;
    if (fld_ok[WO_REG]) begin
      map_next.reg_pos = wbyte[REG_POS_LSB+:4];
    end
    if (fld_wr[WO_EE]) begin
      map_next.ee_en = wbyte[EE_EN_BIT];
      if (!P_EE_POS_ONCE || fld_ok[WO_EE]) begin
        map_next.ee_base = wbyte[EE_POS_LSB+:5];
      end
    end
    if (fld_ok[WO_STR]) begin
      map_next.stretch = wbyte[STR_LSB+:2];
    end
    if (fld_ok[WO_HIDE]) begin
      map_next.hide = wbyte[HIDE_BIT];
    end
    if (fld_ok[WO_FLASH]) begin
      map_next.flash_en = wbyte[FLASH_BIT];
    end
  end

  // The new value is registered at the completing edge and used next cycle.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      map_reg.reg_pos <= P_REG_POS_RST;
      map_reg.ee_base <= P_EE_BASE_RST;
      map_reg.ee_en <= P_EE_EN_RST;
      map_reg.stretch <= STR_RST;
      map_reg.hide <= HIDE_RST;
      map_reg.flash_en <= flash_rst;
      once_reg <= '0;
    end else begin
      map_reg <= map_next;
      once_reg <= once_next;
    end
  end

  // Address decode; register block wins over EEPROM, EEPROM over flash.
  always_comb begin
    logic [1:0] qtr;
    logic [4:0] top;
    qtr = i_cpu_addr[15:14];
    top = i_cpu_addr[15:BASE_LSB];
    hit_next = '0;
    hit_next.reg_hit = (top == {1'b0, map_reg.reg_pos})
                    && (P_REG_2K || !i_cpu_addr[HALF_BIT]);
    hit_next.ee_hit = map_reg.ee_en && (top == map_reg.ee_base)
                   && !hit_next.reg_hit;
    hit_next.flash_hit = map_reg.flash_en && !hit_next.reg_hit
                      && !hit_next.ee_hit
                      && ((qtr == QTR_HIGH_FIXED) || (qtr == QTR_WINDOW)
                      || (qtr == QTR_LOW_FIXED && !map_reg.hide));
    hit_next.ext_hit = !single && !hit_next.reg_hit && !hit_next.ee_hit
                    && !hit_next.flash_hit;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      hit_reg <= '0;
    end else begin
      hit_reg <= hit_next;
    end
  end

  assign o_avs_readdata = rdata_reg;
  assign o_avs_waitrequest = wait_reg;
  assign o_hit = hit_reg;
  assign o_map = omap_reg;

  // Pin copy of the map, registered so that the output comes from a flop.
  // Stretch is forced to zero where there is no external bus; a mode change
  // without reset therefore reaches the pin one cycle late.
  always_comb begin
    omap_next = map_next;
    if (i_rst) begin
      omap_next.reg_pos = P_REG_POS_RST;
      omap_next.ee_base = P_EE_BASE_RST;
      omap_next.ee_en = P_EE_EN_RST;
      omap_next.stretch = STR_RST;
      omap_next.hide = HIDE_RST;
      omap_next.flash_en = flash_rst;
    end
    if (single) begin
      omap_next.stretch = 2'h0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    omap_reg <= omap_next;
  end

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  a_reg_once: assert property (
    (!special && once_reg[WO_REG] && wr_fire && i_avs_address == IDX_REG_POS)
    |=> $stable(map_reg.reg_pos))
    else $error("register position changed after its one write");
  a_reg_low32k: assert property (
    hit_reg.reg_hit |-> 1'b1 ##0 !$past(i_cpu_addr[15]))
    else $error("register block decoded above 32K");
  a_ee_off: assert property (
    !map_reg.ee_en |=> !hit_reg.ee_hit)
    else $error("EEPROM decoded while disabled");
  a_ee_en_free: assert property (
    (wr_fire && i_avs_address == IDX_EE_POS)
    |=> map_reg.ee_en == $past(i_avs_writedata[EE_EN_BIT]))
    else $error("EEPROM enable write lost");
  a_misc_delay: assert property (
    (special && wr_fire && i_avs_address == IDX_MISC)
    |=> o_map.flash_en == $past(i_avs_writedata[FLASH_BIT]))
    else $error("flash enable not updated one cycle after write");
  a_misc_once: assert property (
    (!special && once_reg[WO_STR] && wr_fire && i_avs_address == IDX_MISC)
    |=> $stable(map_reg.stretch) && $stable(map_reg.flash_en))
    else $error("misc field changed after its one write");
  a_stretch_single: assert property (
    single |=> o_map.stretch == 2'h0)
    else $error("stretch active without external bus");
  a_hide_low: assert property (
    (map_reg.hide && i_cpu_addr[15:14] == QTR_LOW_FIXED)
    |=> !hit_reg.flash_hit)
    else $error("low fixed flash reachable while hidden");
  a_flash_off: assert property (
    !map_reg.flash_en |=> !hit_reg.flash_hit)
    else $error("flash decoded while disabled");
  a_test_ro: assert property (
    (wr_fire && (i_avs_address == IDX_TEST_A
    || i_avs_address == IDX_TEST_B)) |=> $stable(map_reg))
    else $error("test register write changed state");
  a_bus_answer: assert property (
    (st_reg == ST_IDLE && (i_avs_read || i_avs_write))
    |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("access not answered in one cycle");
  a_flag_set: assert property (
    fld_wr[WO_HIDE] |=> once_reg[WO_HIDE])
    else $error("write-once flag not set by a write");
  a_flag_sticky: assert property (
    once_reg[WO_REG] |=> once_reg[WO_REG])
    else $error("write-once flag cleared without reset");

  // Free writes in special modes or to a free EEPROM position, and reset values after release.
  a_reg_free: assert property (
    (special && wr_fire && i_avs_address == IDX_REG_POS)
    |=> map_reg.reg_pos == $past(wbyte[REG_POS_LSB+:4]))
    else $error("register position write lost in special mode");
  a_ee_base_free: assert property (
    (!P_EE_POS_ONCE && wr_fire && i_avs_address == IDX_EE_POS)
    |=> map_reg.ee_base == $past(wbyte[EE_POS_LSB+:5]))
    else $error("EEPROM position write lost");
  a_misc_free: assert property (
    (special && wr_fire && i_avs_address == IDX_MISC)
    |=> map_reg.stretch == $past(wbyte[STR_LSB+:2])
    && map_reg.hide == $past(wbyte[HIDE_BIT]))
    else $error("misc write lost in special mode");
  a_rst_misc: assert property (
    $past(i_rst) |-> map_reg.stretch == STR_RST
    && map_reg.hide == HIDE_RST && map_reg.flash_en == $past(flash_rst))
    else $error("misc fields not at reset values");

  // Decode and bus read-back.
  a_reg_low_half: assert property (
    (i_cpu_addr[15:BASE_LSB] == {1'b0, map_reg.reg_pos}
    && !i_cpu_addr[HALF_BIT]) |=> hit_reg.reg_hit)
    else $error("register block missed in its first 1K");
  a_ee_base_hit: assert property (
    hit_reg.ee_hit
    |-> $past(i_cpu_addr[15:BASE_LSB]) == $past(map_reg.ee_base))
    else $error("EEPROM decoded away from its base");
  a_window_reach: assert property (
    (map_reg.flash_en && !map_reg.ee_en
    && i_cpu_addr[15:14] == QTR_WINDOW) |=> hit_reg.flash_hit)
    else $error("page window not decoded to flash");
  a_ext_single: assert property (
    single |=> !hit_reg.ext_hit)
    else $error("external space decoded without external bus");
  a_one_target: assert property (
    $onehot0(hit_reg))
    else $error("more than one decode target hit");
  a_test_read: assert property (
    (st_reg == ST_IDLE && i_avs_read && i_avs_address == IDX_TEST_A)
    |=> o_avs_readdata == {24'h000000, P_TEST_A_VAL})
    else $error("test register read wrong value");
  a_pos_bit7: assert property (
    (st_reg == ST_IDLE && i_avs_read && i_avs_address == IDX_REG_POS)
    |=> !o_avs_readdata[REG_POS_LSB+4])
    else $error("fixed zero above the register position reads one");
  a_read_upper: assert property (
    !o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h000000)
    else $error("read data above lane 0 not zero");
  a_wait_idle: assert property (
    (st_reg == ST_IDLE && !i_avs_read && !i_avs_write)
    |=> o_avs_waitrequest)
    else $error("waitrequest low without a request");

  c_reg_write: cover property (wr_fire && i_avs_address == IDX_REG_POS);
  c_blocked: cover property (fld_wr[WO_STR] && !fld_ok[WO_STR]);
  c_ee_hit: cover property (hit_reg.ee_hit);
  c_window: cover property (map_reg.hide && hit_reg.flash_hit);
  c_spec_rewrite: cover property (special && wr_fire && once_reg[WO_REG]);
endmodule

// *** hdl/mmp_pkg.sv ***
// Package with the map-control register layout, modes and carrier types.
package mmp_pkg;
  // Word indices of the registers; byte address is four times the index.
  localparam logic [2:0] IDX_REG_POS = 3'h0;
  localparam logic [2:0] IDX_EE_POS = 3'h1;
  localparam logic [2:0] IDX_MISC = 3'h2;
  localparam logic [2:0] IDX_TEST_A = 3'h3;
  localparam logic [2:0] IDX_TEST_B = 3'h4;
  // Field positions inside the 8-bit registers.
  localparam int REG_POS_LSB = 3;
  localparam int EE_POS_LSB = 3;
  localparam int EE_EN_BIT = 0;
  localparam int STR_LSB = 2;
  localparam int HIDE_BIT = 1;
  localparam int FLASH_BIT = 0;
  // Reset values of the miscellaneous control fields.
  localparam logic [1:0] STR_RST = 2'h3;
  localparam logic HIDE_RST = 1'b0;
  localparam logic FLASH_RST_ON = 1'b1;
  localparam logic FLASH_RST_TEST = 1'b0;
  // Address decode fields of the 16-bit core address.
  localparam int BASE_LSB = 11;
  localparam int HALF_BIT = 10;
  localparam logic [1:0] QTR_LOW_FIXED = 2'h1;
  localparam logic [1:0] QTR_WINDOW = 2'h2;
  localparam logic [1:0] QTR_HIGH_FIXED = 2'h3;
  // Write-once flag index per field.
  localparam int WO_REG = 0;
  localparam int WO_EE = 1;
  localparam int WO_STR = 2;
  localparam int WO_HIDE = 3;
  localparam int WO_FLASH = 4;
  localparam int WO_N = 5;

  typedef enum logic [2:0] {
    MD_NORM_SINGLE = 3'h0,
    MD_NORM_EXP = 3'h1,
    MD_EMUL = 3'h2,
    MD_PERIPH = 3'h3,
    MD_SPEC_SINGLE = 3'h4,
    MD_SPEC_TEST = 3'h5
  } mmp_mode_t;

  typedef struct packed {
    logic [3:0] reg_pos;
    logic [4:0] ee_base;
    logic ee_en;
    logic [1:0] stretch;
    logic hide;
    logic flash_en;
  } mmp_map_t;

  typedef struct packed {
    logic reg_hit;
    logic ee_hit;
    logic flash_hit;
    logic ext_hit;
  } mmp_hit_t;
endpackage

// *** verif/mmp_ctrl_tb.sv ***
// Self-checking testbench for the map position control registers.
`timescale 1ns/1ns
module mmp_ctrl_tb
  import mmp_pkg::*;
;
  typedef struct {
    logic [2:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } mmp_row_t;

  logic i_core_clk;
  logic i_rst;
  mmp_mode_t i_mode;
  logic [2:0] i_avs_address;
  logic i_avs_read;
  logic i_avs_write;
  logic [31:0] i_avs_writedata;
  logic [3:0] i_avs_byteenable;
  logic [15:0] i_cpu_addr;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest;
  mmp_map_t o_map;
  mmp_hit_t o_hit;
  logic [31:0] rd;
  int n_errors = 0;
  int n_checks = 0;
  int cycles = 0;

  // Normal expanded mode: second writes to write-once fields must bounce.
  mmp_row_t rows [9] = '{
    '{IDX_REG_POS, 8'h28, 8'h28},
    '{IDX_REG_POS, 8'h30, 8'h28},
    '{IDX_EE_POS, 8'h60, 8'h60},
    '{IDX_EE_POS, 8'h51, 8'h51},
    '{IDX_MISC, 8'h06, 8'h06},
    '{IDX_MISC, 8'h0d, 8'h06},
    '{IDX_TEST_A, 8'hff, 8'h00},
    '{IDX_TEST_B, 8'h5a, 8'h00},
    '{3'h5, 8'h33, 8'h00}
  };

  mmp_ctrl dut (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_mode(i_mode),
    .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable),
    .i_cpu_addr(i_cpu_addr),
    .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest),
    .o_map(o_map),
    .o_hit(o_hit)
  );

  initial begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end

  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // A hung handshake would otherwise stall the run forever.
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Only the bench timeout ends a wait that never sees waitrequest low.
  task automatic bus(logic wr, logic [2:0] a, logic [7:0] d);
    @(posedge i_core_clk);
    i_avs_write <= wr;
    i_avs_read <= !wr;
    i_avs_address <= a;
    i_avs_writedata <= {24'h0, d};
    do begin
      @(posedge i_core_clk);
    end while (o_avs_waitrequest !== 1'b0);
    rd = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask

  task automatic rdchk(logic [2:0] a, logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk("readdata", rd, {24'h0, e});
  endtask

  task automatic hit(logic [15:0] a, logic [3:0] e);
    @(posedge i_core_clk);
    i_cpu_addr <= a;
    repeat (2) @(posedge i_core_clk);
    #1 chk("hit", {28'h0, o_hit}, {28'h0, e});
  endtask

  task automatic rst(mmp_mode_t m);
    @(posedge i_core_clk);
    i_mode <= m;
    i_rst <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    i_rst <= 1'b0;
    @(posedge i_core_clk);
  endtask

  initial begin
    i_rst = 1'b1;
    i_mode = MD_NORM_EXP;
    i_avs_address = 3'h0;
    i_avs_read = 1'b0;
    i_avs_write = 1'b0;
    i_avs_writedata = 32'h0;
    i_avs_byteenable = 4'h1;
    i_cpu_addr = 16'h0;
    rst(MD_NORM_EXP);
    rdchk(IDX_MISC, 8'h0c);
    chk("stretch", {30'h0, o_map.stretch}, 32'h3);
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d);
      rdchk(rows[i].a, rows[i].e);
    end
    chk("stretch", {30'h0, o_map.stretch}, 32'h1);
    hit(16'h2800, 4'h8);
    hit(16'h2c00, 4'h8);
    hit(16'h5000, 4'h4);
    hit(16'hc000, 4'h1);
    // Special single-chip mode: all fields free, stretch masked.
    rst(MD_SPEC_SINGLE);
    rdchk(IDX_MISC, 8'h0d);
    chk("stretch", {30'h0, o_map.stretch}, 32'h0);
    bus(1'b1, IDX_REG_POS, 8'h78);
    bus(1'b1, IDX_REG_POS, 8'h10);
    rdchk(IDX_REG_POS, 8'h10);
    hit(16'h1000, 4'h8);
    hit(16'h4000, 4'h2);
    bus(1'b1, IDX_MISC, 8'h03);
    hit(16'h4000, 4'h0);
    hit(16'h8000, 4'h2);
    bus(1'b1, IDX_MISC, 8'h02);
    hit(16'hc000, 4'h0);
    bus(1'b1, IDX_EE_POS, 8'h79);
    #1 chk("ee_map", {26'h0, o_map.ee_base, o_map.ee_en}, 32'h1f);
    hit(16'h7800, 4'h4);
    bus(1'b1, IDX_EE_POS, 8'h78);
    hit(16'h7800, 4'h0);
    // Special test mode: flash starts off and stretch is visible.
    rst(MD_SPEC_TEST);
    rdchk(IDX_MISC, 8'h0c);
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, IDX_MISC, {4'h0, c[1:0], 2'h0});
      #1 chk("stretch", {30'h0, o_map.stretch}, c);
    end
    // Peripheral counts as special, emulation does not; normal single-chip masks stretch.
    rst(MD_PERIPH);
    rdchk(IDX_MISC, 8'h0d);
    bus(1'b1, IDX_REG_POS, 8'h18);
    bus(1'b1, IDX_REG_POS, 8'h20);
    rdchk(IDX_REG_POS, 8'h20);
    rst(MD_NORM_SINGLE);
    rdchk(IDX_MISC, 8'h0d);
    chk("stretch", {30'h0, o_map.stretch}, 32'h0);
    hit(16'hc000, 4'h2);
    rst(MD_EMUL);
    rdchk(IDX_MISC, 8'h0c);
    bus(1'b1, IDX_MISC, 8'h01);
    bus(1'b1, IDX_MISC, 8'h00);
    rdchk(IDX_MISC, 8'h01);
    bus(1'b1, IDX_EE_POS, 8'h01);
    bus(1'b1, IDX_EE_POS, 8'h00);
    rdchk(IDX_EE_POS, 8'h00);
    complete_run();
  end
endmodule
